// ### rtl/rtc_block_consts.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: byte-wide register port, 16-bit address
// Notes:   offsets are the byte addresses of the register port
`ifndef RTC_BLOCK_CONSTS_SVH
`define RTC_BLOCK_CONSTS_SVH

`define ADDR_ANALOG_TRIM   16'h2504
`define ADDR_LOOKUP_ADDR   16'h2887
`define ADDR_LOOKUP_DATA   16'h2888
`define ADDR_LOOKUP_STROBE 16'h2889
`define ADDR_CONTROL       16'h2890
`define ADDR_SUBSECOND     16'h2892
`define ADDR_SECONDS       16'h2893
`define ADDR_MINUTES       16'h2894
`define ADDR_HOURS         16'h2895
`define ADDR_WEEKDAY       16'h2896
`define ADDR_DATE          16'h2897
`define ADDR_MONTH         16'h2898
`define ADDR_YEAR          16'h2899
`define ADDR_RATE_HIGH     16'h289B
`define ADDR_RATE_MID      16'h289C
`define ADDR_RATE_LOW      16'h289D
`define ADDR_ALARM_MIN     16'h289E
`define ADDR_ALARM_HR      16'h289F
`define ADDR_TEMP_CTRL     16'h28A0
`define ADDR_IRQ_STATUS    16'h28C0
`define ADDR_IRQ_MASK      16'h28C1

`define BIT_AUTO_INC       7
`define BIT_LOOKUP_RD      1
`define BIT_LOOKUP_WR      0
`define BIT_COUNT_FAIL     4
`define BIT_FREEZE_RD      6
`define BIT_FREEZE_WR      7
`define BIT_TEMP_UPDATE    5

`define RST_ANALOG_TRIM    7'h40
`define RST_RATE_MAIN      17'h10000
`define RATE_MAIN_MIN      17'h0FFBF
`define RATE_MAIN_MAX      17'h10040

`define IRQ_ALARM          0
`define IRQ_FAIL           1

`define CLK_HZ             100000000
`define SLOW_TICK_HZ       1000
`define SLOW_TICK_CYCLES   (`CLK_HZ / `SLOW_TICK_HZ)
`define TICKS_PER_SUBSEC   8
`define SUBSEC_STEPS       128
`define LOOKUP_LATENCY     2

`endif

// ### rtl/rtc_block_pkg.sv
// Purpose: shared types of the clock block
// Assumes: nothing
// Notes:   constants live in the consts header
package rtc_block_pkg;

	typedef struct packed
	{
		logic [7:0] year;
		logic [3:0] month;
		logic [4:0] date;
		logic [2:0] weekday;
		logic [4:0] hours;
		logic [5:0] minutes;
		logic [5:0] seconds;
	} calendar_s;

	typedef struct packed
	{
		logic [16:0] main;
		logic [1:0]  fraction;
	} rate_adjust_s;

	typedef enum logic [1:0]
	{
		LK_IDLE  = 2'b00,
		LK_BUSY  = 2'b01,
		LK_DONE  = 2'b10
	} lookup_state_e;

endpackage

// ### rtl/rtc_calendar_step.sv
// Purpose: one-second advance of the calendar
// Assumes: input calendar fields hold legal values
// Notes:   purely combinational
`include "rtc_block_consts.svh"
module rtc_calendar_step
	import rtc_block_pkg::*;
(
	// calendar in and out
	input  wire calendar_s i_now,
	output calendar_s      o_next
);

	function automatic logic [4:0] month_days(input logic [3:0] m, input logic [7:0] y);
		logic leap;
		leap = (y[1:0] == 2'h0);
		case (m)
			4'h2:    month_days = leap ? 5'h1D : 5'h1C;
			4'h4, 4'h6, 4'h9, 4'hB: month_days = 5'h1E;
			default: month_days = 5'h1F;
		endcase
	endfunction

	wire sec_wrap  = (i_now.seconds == 6'h3B);
	wire min_wrap  = sec_wrap && (i_now.minutes == 6'h3B);
	wire hr_wrap   = min_wrap && (i_now.hours == 5'h17);
	wire date_wrap = hr_wrap && (i_now.date == month_days(i_now.month, i_now.year));
	wire mon_wrap  = date_wrap && (i_now.month == 4'hC);

	always_comb
	begin
		o_next = i_now;
		o_next.seconds = sec_wrap ? 6'h00 : i_now.seconds + 6'h01;
		if (sec_wrap)
			o_next.minutes = min_wrap ? 6'h00 : i_now.minutes + 6'h01;
		if (min_wrap)
			o_next.hours = hr_wrap ? 5'h00 : i_now.hours + 5'h01;
		if (hr_wrap)
		begin
			o_next.weekday = (i_now.weekday == 3'h7) ? 3'h1 : i_now.weekday + 3'h1;
			o_next.date = date_wrap ? 5'h01 : i_now.date + 5'h01;
		end
		if (date_wrap)
			o_next.month = mon_wrap ? 4'h1 : i_now.month + 4'h1;
		if (mon_wrap)
			o_next.year = (i_now.year == 8'h63) ? 8'h00 : i_now.year + 8'h01;
	end

endmodule

// ### rtl/rtc_lookup_ram.sv
// Purpose: lookup memory behind the indirect access port
// Assumes: single access in flight
// Notes:   flip-flop storage, read data registered
module rtc_lookup_ram #(
	parameter int DEPTH = 128,
	parameter int AW    = 7
) (
	// clock and reset
	input  wire             i_ref_clk,
	input  wire             i_rst,
	// access
	input  wire             i_wr,
	input  wire [AW-1:0]    i_addr,
	input  wire [7:0]       i_wdata,
	output logic [7:0]      o_rdata
);

	logic [7:0] mem_reg [DEPTH];

	always_ff @(posedge i_ref_clk)
	begin
		if (i_wr)
			mem_reg[i_addr] <= i_wdata;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			o_rdata <= 8'h00;
		else
			o_rdata <= mem_reg[i_addr];
	end

endmodule

// ### rtl/rtc_block.sv
// Purpose: real-time clock register block with shadow, alarm and lookup port
// Assumes: byte register port, one access per cycle, temperature done pulse
// Notes:   slow tick derived from the 100 MHz clock by a divider
`include "rtc_block_consts.svh"
module rtc_block
	import rtc_block_pkg::*;
#(
	parameter int SLOW_TICK_CYCLES = `SLOW_TICK_CYCLES,
	parameter int LOOKUP_DEPTH     = 128
) (
	// clock and reset
	input  wire                i_ref_clk,
	input  wire                i_rst,
	// register port
	input  wire [15:0]         i_addr,
	input  wire [7:0]          i_wdata,
	input  wire                i_wr,
	input  wire                i_rd,
	output logic [7:0]         o_rdata,
	// temperature and fault inputs
	input  wire                i_temp_done,
	input  wire rate_adjust_s  i_temp_rate,
	input  wire                i_count_error,
	// outputs
	output logic [6:0]         o_analog_trim,
	output rate_adjust_s       o_rate_adjust,
	output logic               o_irq
);

	localparam int TW = $clog2(SLOW_TICK_CYCLES);

	// registers
	logic [TW-1:0]  tick_cnt_reg;
	logic [2:0]     subtick_reg;
	logic [6:0]     subsec_reg;
	calendar_s      count_reg;
	calendar_s      shadow_reg;
	logic           freeze_rd_reg;
	logic           freeze_wr_reg;
	logic           load_pend_reg;
	logic           fail_reg;
	logic [6:0]     trim_reg;
	rate_adjust_s   rate_reg;
	logic [5:0]     alarm_min_reg;
	logic [4:0]     alarm_hr_reg;
	logic           temp_upd_reg;
	logic [6:0]     lk_addr_reg;
	logic           lk_auto_reg;
	logic [7:0]     lk_data_reg;
	logic           lk_rd_reg;
	logic           lk_wr_reg;
	lookup_state_e  lk_state_reg;
	logic [1:0]     irq_stat_reg;
	logic [1:0]     irq_mask_reg;
	logic           match_prev_reg;

	// decode
	wire wr_trim   = i_wr && (i_addr == `ADDR_ANALOG_TRIM);
	wire wr_lkaddr = i_wr && (i_addr == `ADDR_LOOKUP_ADDR);
	wire wr_lkdata = i_wr && (i_addr == `ADDR_LOOKUP_DATA);
	wire wr_lkstb  = i_wr && (i_addr == `ADDR_LOOKUP_STROBE);
	wire wr_ctrl   = i_wr && (i_addr == `ADDR_CONTROL);
	wire wr_sec    = i_wr && (i_addr == `ADDR_SECONDS);
	wire wr_min    = i_wr && (i_addr == `ADDR_MINUTES);
	wire wr_hr     = i_wr && (i_addr == `ADDR_HOURS);
	wire wr_day    = i_wr && (i_addr == `ADDR_WEEKDAY);
	wire wr_date   = i_wr && (i_addr == `ADDR_DATE);
	wire wr_mon    = i_wr && (i_addr == `ADDR_MONTH);
	wire wr_yr     = i_wr && (i_addr == `ADDR_YEAR);
	wire wr_rhi    = i_wr && (i_addr == `ADDR_RATE_HIGH);
	wire wr_rmid   = i_wr && (i_addr == `ADDR_RATE_MID);
	wire wr_rlo    = i_wr && (i_addr == `ADDR_RATE_LOW);
	wire wr_amin   = i_wr && (i_addr == `ADDR_ALARM_MIN);
	wire wr_ahr    = i_wr && (i_addr == `ADDR_ALARM_HR);
	wire wr_temp   = i_wr && (i_addr == `ADDR_TEMP_CTRL);
	wire wr_istat  = i_wr && (i_addr == `ADDR_IRQ_STATUS);
	wire wr_imask  = i_wr && (i_addr == `ADDR_IRQ_MASK);
	wire wr_cal    = wr_sec | wr_min | wr_hr | wr_day | wr_date | wr_mon | wr_yr;

	// slow tick and sub-second
	wire slow_tick = (tick_cnt_reg == TW'(SLOW_TICK_CYCLES - 1));
	wire sub_step  = slow_tick && (subtick_reg == 3'(`TICKS_PER_SUBSEC - 1));
	wire sec_tick  = sub_step && (subsec_reg == 7'(`SUBSEC_STEPS - 1));
	// 1000 slow ticks per second would be exact; 8x128 trades accuracy for simplicity
	calendar_s step_out;

	rtc_calendar_step u_step
	(
		.i_now  (count_reg),
		.o_next (step_out)
	);

	wire load_now = load_pend_reg && slow_tick;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			tick_cnt_reg <= '0;
			subtick_reg  <= 3'h0;
			subsec_reg   <= 7'h00;
		end
		else
		begin
			tick_cnt_reg <= slow_tick ? '0 : tick_cnt_reg + TW'(1);
			if (slow_tick)
				subtick_reg <= subtick_reg + 3'h1;
			if (sub_step)
				subsec_reg <= subsec_reg + 7'h01;
			if (load_now)
				subsec_reg <= 7'h00;
		end
	end

	// counter: holds a legal date after reset, year 00 jan 1 sunday
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			count_reg <= '{8'h00, 4'h1, 5'h01, 3'h1, 5'h00, 6'h00, 6'h00};
		else if (load_now)
			count_reg <= shadow_reg;
		else if (sec_tick)
			count_reg <= step_out;
	end

	// shadow follows counter unless frozen or a load is pending
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			shadow_reg <= '{8'h00, 4'h1, 5'h01, 3'h1, 5'h00, 6'h00, 6'h00};
		else if (freeze_wr_reg)
		begin
			if (wr_sec)  shadow_reg.seconds <= i_wdata[5:0];
			if (wr_min)  shadow_reg.minutes <= i_wdata[5:0];
			if (wr_hr)   shadow_reg.hours   <= i_wdata[4:0];
			if (wr_day)  shadow_reg.weekday <= i_wdata[2:0];
			if (wr_date) shadow_reg.date    <= i_wdata[4:0];
			if (wr_mon)  shadow_reg.month   <= i_wdata[3:0];
			if (wr_yr)   shadow_reg.year    <= i_wdata;
		end
		else if (!freeze_rd_reg && !load_pend_reg)
			shadow_reg <= count_reg;
	end

	// control byte; a pending load keeps the shadow until taken
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			freeze_rd_reg <= 1'b0;
			freeze_wr_reg <= 1'b0;
			load_pend_reg <= 1'b0;
			fail_reg      <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				freeze_rd_reg <= i_wdata[`BIT_FREEZE_RD];
				freeze_wr_reg <= i_wdata[`BIT_FREEZE_WR];
			end
			if (wr_ctrl && freeze_wr_reg && !i_wdata[`BIT_FREEZE_WR])
				load_pend_reg <= 1'b1;
			else if (load_now)
				load_pend_reg <= 1'b0;
			if (i_count_error)
				fail_reg <= 1'b1;
			else if (wr_ctrl && !i_wdata[`BIT_COUNT_FAIL])
				fail_reg <= 1'b0;
		end
	end

	// rate adjust, trim, alarm target, temperature control
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			trim_reg      <= `RST_ANALOG_TRIM;
			rate_reg      <= '{`RST_RATE_MAIN, 2'h0};
			alarm_min_reg <= 6'h00;
			alarm_hr_reg  <= 5'h00;
			temp_upd_reg  <= 1'b0;
		end
		else
		begin
			if (wr_trim) trim_reg <= i_wdata[6:0];
			if (wr_rhi)  rate_reg.main[16:14] <= i_wdata[2:0];
			if (wr_rmid) rate_reg.main[13:6]  <= i_wdata;
			if (wr_rlo)
			begin
				rate_reg.main[5:0] <= i_wdata[7:2];
				rate_reg.fraction  <= i_wdata[1:0];
			end
			if (temp_upd_reg && i_temp_done)
				rate_reg <= i_temp_rate;
			if (wr_amin) alarm_min_reg <= i_wdata[5:0];
			if (wr_ahr)  alarm_hr_reg  <= i_wdata[4:0];
			if (wr_temp) temp_upd_reg  <= i_wdata[`BIT_TEMP_UPDATE];
		end
	end

	// lookup port
	wire [7:0] lk_rdata;
	wire       lk_go   = wr_lkstb && (lk_state_reg == LK_IDLE)
	                     && (i_wdata[`BIT_LOOKUP_RD] || i_wdata[`BIT_LOOKUP_WR]);
	wire       lk_done = (lk_state_reg == LK_DONE);

	rtc_lookup_ram #(
		.DEPTH (LOOKUP_DEPTH),
		.AW    (7)
	) u_ram (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_wr      (lk_done && lk_wr_reg),
		.i_addr    (lk_addr_reg),
		.i_wdata   (lk_data_reg),
		.o_rdata   (lk_rdata)
	);

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			lk_state_reg <= LK_IDLE;
			lk_rd_reg    <= 1'b0;
			lk_wr_reg    <= 1'b0;
			lk_addr_reg  <= 7'h00;
			lk_auto_reg  <= 1'b0;
			lk_data_reg  <= 8'h00;
		end
		else
		begin
			unique case (lk_state_reg)
				LK_IDLE:
				begin
					if (lk_go)
					begin
						lk_rd_reg    <= i_wdata[`BIT_LOOKUP_RD];
						lk_wr_reg    <= i_wdata[`BIT_LOOKUP_WR] && !i_wdata[`BIT_LOOKUP_RD];
						lk_state_reg <= LK_BUSY;
					end
				end
				LK_BUSY: lk_state_reg <= LK_DONE;
				LK_DONE:
				begin
					lk_state_reg <= LK_IDLE;
					lk_rd_reg    <= 1'b0;
					lk_wr_reg    <= 1'b0;
				end
				default: lk_state_reg <= LK_IDLE;
			endcase
			// address and data are locked while an access runs
			if (wr_lkaddr && lk_state_reg == LK_IDLE)
			begin
				lk_addr_reg <= i_wdata[6:0];
				lk_auto_reg <= i_wdata[`BIT_AUTO_INC];
			end
			else if (lk_done && lk_auto_reg)
				lk_addr_reg <= lk_addr_reg + 7'h01;
			if (wr_lkdata && lk_state_reg == LK_IDLE)
				lk_data_reg <= i_wdata;
			else if (lk_done && lk_rd_reg)
				lk_data_reg <= lk_rdata;
		end
	end

	// alarm: edge of the equality so it fires once per match
	wire alarm_match = (count_reg.minutes == alarm_min_reg)
	                   && (count_reg.hours == alarm_hr_reg);
	wire alarm_evt   = alarm_match && !match_prev_reg;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			match_prev_reg <= 1'b1;
			irq_stat_reg   <= 2'h0;
			irq_mask_reg   <= 2'h0;
		end
		else
		begin
			match_prev_reg <= alarm_match;
			// set wins over a same-cycle clear
			irq_stat_reg <= (irq_stat_reg & ~(wr_istat ? i_wdata[1:0] : 2'h0))
			                | {i_count_error, alarm_evt};
			if (wr_imask)
				irq_mask_reg <= i_wdata[1:0];
		end
	end

	assign o_irq = |(irq_stat_reg & irq_mask_reg);

	// read mux
	logic [7:0] rd_mux;

	always_comb
	begin
		rd_mux = 8'h00;
		unique case (i_addr)
			`ADDR_ANALOG_TRIM:   rd_mux = {1'b0, trim_reg};
			`ADDR_LOOKUP_ADDR:   rd_mux = {lk_auto_reg, lk_addr_reg};
			`ADDR_LOOKUP_DATA:   rd_mux = lk_data_reg;
			`ADDR_LOOKUP_STROBE: rd_mux = {6'h00, lk_rd_reg, lk_wr_reg};
			`ADDR_CONTROL:       rd_mux = {freeze_wr_reg | load_pend_reg,
			                               freeze_rd_reg, 1'b0, fail_reg, 4'h0};
			`ADDR_SUBSECOND:     rd_mux = 8'(`SUBSEC_STEPS - 1) - {1'b0, subsec_reg};
			`ADDR_SECONDS:       rd_mux = {2'h0, shadow_reg.seconds};
			`ADDR_MINUTES:       rd_mux = {2'h0, shadow_reg.minutes};
			`ADDR_HOURS:         rd_mux = {3'h0, shadow_reg.hours};
			`ADDR_WEEKDAY:       rd_mux = {5'h00, shadow_reg.weekday};
			`ADDR_DATE:          rd_mux = {3'h0, shadow_reg.date};
			`ADDR_MONTH:         rd_mux = {4'h0, shadow_reg.month};
			`ADDR_YEAR:          rd_mux = shadow_reg.year;
			`ADDR_RATE_HIGH:     rd_mux = {5'h00, rate_reg.main[16:14]};
			`ADDR_RATE_MID:      rd_mux = rate_reg.main[13:6];
			`ADDR_RATE_LOW:      rd_mux = {rate_reg.main[5:0], rate_reg.fraction};
			`ADDR_ALARM_MIN:     rd_mux = {2'h0, alarm_min_reg};
			`ADDR_ALARM_HR:      rd_mux = {3'h0, alarm_hr_reg};
			`ADDR_TEMP_CTRL:     rd_mux = {2'h0, temp_upd_reg, 5'h00};
			`ADDR_IRQ_STATUS:    rd_mux = {6'h00, irq_stat_reg};
			`ADDR_IRQ_MASK:      rd_mux = {6'h00, irq_mask_reg};
			default:             rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			o_rdata <= 8'h00;
		else
			o_rdata <= i_rd ? rd_mux : 8'h00;
	end

	assign o_analog_trim = trim_reg;
	assign o_rate_adjust = rate_reg;

endmodule

// ### dv/rtc_block_asserts.sv
// Purpose: port-level checks of the clock register block
// Assumes: byte register port, one clock domain
// Notes:   internal state unseen, so only port relations
`include "rtc_block_consts.svh"
module rtc_block_asserts
	import rtc_block_pkg::*;
#(
	parameter int SLOW_TICK_CYCLES = `SLOW_TICK_CYCLES,
	parameter int LOOKUP_DEPTH     = 128
) (
	input wire logic         i_ref_clk,
	input wire logic         i_rst,
	input wire logic [15:0]  i_addr,
	input wire logic [7:0]   i_wdata,
	input wire logic         i_wr,
	input wire logic         i_rd,
	input wire logic [7:0]   o_rdata,
	input wire logic         i_temp_done,
	input wire rate_adjust_s i_temp_rate,
	input wire logic         i_count_error,
	input wire logic [6:0]   o_analog_trim,
	input wire rate_adjust_s o_rate_adjust,
	input wire logic         o_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	a_trim_reset: assert property ($fell(i_rst) |-> o_analog_trim == `RST_ANALOG_TRIM)
		else $error("trim not at reset value");
	a_trim_write: assert property (i_wr && i_addr == `ADDR_ANALOG_TRIM |=>
		o_analog_trim == $past(i_wdata[6:0])) else $error("trim write lost");
	a_trim_hold: assert property (!(i_wr && i_addr == `ADDR_ANALOG_TRIM) |=>
		$stable(o_analog_trim)) else $error("trim changed without write");
	a_trim_read: assert property (i_rd && i_addr == `ADDR_ANALOG_TRIM |=>
		o_rdata == {1'b0, $past(o_analog_trim)}) else $error("trim read wrong");
	a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data outside read slot");
	a_rate_reset: assert property ($fell(i_rst) |-> o_rate_adjust == {`RST_RATE_MAIN, 2'b00})
		else $error("rate not at reset value");
	a_rate_mid: assert property (i_wr && i_addr == `ADDR_RATE_MID && !i_temp_done |=>
		o_rate_adjust.main[13:6] == $past(i_wdata)) else $error("rate middle write lost");
	a_rate_quiet: assert property (!i_wr && !i_temp_done |=> $stable(o_rate_adjust))
		else $error("rate changed without cause");
	a_irq_masked: assert property (i_wr && i_addr == `ADDR_IRQ_MASK && i_wdata == 8'h00
		|=> !o_irq) else $error("irq high with all masked");
	a_sub_range: assert property (i_rd && i_addr == `ADDR_SUBSECOND |=> !o_rdata[7])
		else $error("subsecond above 127");
endmodule

bind rtc_block rtc_block_asserts #(
	.SLOW_TICK_CYCLES(SLOW_TICK_CYCLES),
	.LOOKUP_DEPTH    (LOOKUP_DEPTH)
) i_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_temp_done(i_temp_done),
	.i_temp_rate(i_temp_rate), .i_count_error(i_count_error),
	.o_analog_trim(o_analog_trim), .o_rate_adjust(o_rate_adjust), .o_irq(o_irq));

// ### dv/rtc_calendar_shadow_lookup_tb.sv
// Purpose: self-checking bench of the clock register block
// Assumes: slow tick cut to 4 cycles, so one second is 4096 cycles
// Notes:   reads note expectations in a queue; a negedge monitor compares
`include "rtc_block_consts.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module rtc_calendar_shadow_lookup_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rtc_block_pkg::*;
	localparam int TICK = 4;
	typedef struct {logic [7:0] e; logic [7:0] m;} note_s;
	logic         ref_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_pend = 1'b0;
	logic         temp_done = 1'b0, count_error = 1'b0, irq;
	logic [15:0]  addr = 16'h0000;
	logic [7:0]   wdata = 8'h00, rdata;
	logic [6:0]   trim;
	logic [31:0]  seed = 32'h8, r;
	rate_adjust_s temp_rate = '0, rate_adjust;
	note_s        q[$];
	int           n_fail = 0, n_compared = 0;

	rtc_block #(.SLOW_TICK_CYCLES(TICK), .LOOKUP_DEPTH(128)) i_dut (.i_ref_clk(ref_clk),
		.i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_temp_done(temp_done), .i_temp_rate(temp_rate), .i_count_error(count_error),
		.o_analog_trim(trim), .o_rate_adjust(rate_adjust), .o_irq(irq));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
	endtask
	task automatic rx(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
		q.push_back('{e & m, m});
		bus(1'b0, a, 8'h00);
	endtask
	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic pulse_temp(input rate_adjust_s v);
		temp_rate <= v;
		temp_done <= 1'b1;
		@(posedge ref_clk);
		temp_done <= 1'b0;
		idle(1);
		@(negedge ref_clk);
	endtask
	task automatic tally_and_finish();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end
	// read data stands one cycle only, so the monitor must not skip a slot
	always @(negedge ref_clk)
	begin
		note_s n;
		if (rd_pend)
		begin
			n = q.pop_front();
			`CHK(rdata & n.m, n.e)
		end
		rd_pend = rd;
	end
	initial
	begin
		repeat (30000) @(posedge ref_clk);
		n_fail++;
		tally_and_finish();
	end

	initial
	begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rx(`ADDR_ANALOG_TRIM, 8'h40, 8'hFF);
		rx(`ADDR_RATE_HIGH, 8'h04, 8'h07);
		rx(16'h2000, 8'h00, 8'hFF);
		bus(1'b1, 16'h2000, 8'hFF);
		for (int k = 0; k < 4; k++)
		begin
			r = xs();
			bus(1'b1, `ADDR_ANALOG_TRIM, r[7:0]);
			bus(1'b1, `ADDR_RATE_LOW, r[15:8]);
			rx(`ADDR_ANALOG_TRIM, r[7:0], 8'h7F);
			rx(`ADDR_RATE_LOW, r[15:8], 8'hFF);
			idle(1);
			@(negedge ref_clk);
			`CHK(trim, r[6:0])
			`CHK(rate_adjust, {`RST_RATE_MAIN, 2'b00} | 19'(r[15:8]))
			@(posedge ref_clk);
		end
		// lowest legal main value, all three bytes in play
		bus(1'b1, `ADDR_RATE_HIGH, 8'h03);
		bus(1'b1, `ADDR_RATE_MID, 8'hFE);
		bus(1'b1, `ADDR_RATE_LOW, 8'hFE);
		bus(1'b1, `ADDR_TEMP_CTRL, 8'h20);
		idle(1);
		@(negedge ref_clk);
		`CHK(rate_adjust, {17'h0FFBF, 2'b10})
		@(posedge ref_clk);
		pulse_temp({17'h10040, 2'b11});
		`CHK(rate_adjust, {17'h10040, 2'b11})
		@(posedge ref_clk);
		bus(1'b1, `ADDR_TEMP_CTRL, 8'h00);
		idle(1);
		pulse_temp({17'h0FFC0, 2'b01});
		`CHK(rate_adjust, {17'h10040, 2'b11})
		@(posedge ref_clk);
		r = xs();
		bus(1'b1, `ADDR_LOOKUP_DATA, r[7:0]);
		bus(1'b1, `ADDR_LOOKUP_ADDR, 8'hFF);
		bus(1'b1, `ADDR_LOOKUP_STROBE, 8'h01);
		rx(`ADDR_LOOKUP_STROBE, 8'h01, 8'h03);
		idle(4);
		rx(`ADDR_LOOKUP_STROBE, 8'h00, 8'h03);
		rx(`ADDR_LOOKUP_ADDR, 8'h80, 8'hFF);
		bus(1'b1, `ADDR_LOOKUP_DATA, r[15:8]);
		bus(1'b1, `ADDR_LOOKUP_STROBE, 8'h01);
		idle(4);
		bus(1'b1, `ADDR_LOOKUP_ADDR, 8'h7F);
		bus(1'b1, `ADDR_LOOKUP_STROBE, 8'h02);
		idle(4);
		rx(`ADDR_LOOKUP_DATA, r[7:0], 8'hFF);
		rx(`ADDR_LOOKUP_ADDR, 8'h7F, 8'hFF);
		bus(1'b1, `ADDR_LOOKUP_ADDR, 8'h80);
		bus(1'b1, `ADDR_LOOKUP_STROBE, 8'h02);
		idle(4);
		rx(`ADDR_LOOKUP_DATA, r[15:8], 8'hFF);
		rx(`ADDR_LOOKUP_ADDR, 8'h81, 8'hFF);
		// seconds, minutes and hours each go behind their own control write
		for (int k = 0; k < 3; k++)
		begin
			bus(1'b1, `ADDR_CONTROL, 8'h80);
			bus(1'b1, `ADDR_SECONDS + 16'(k), k == 2 ? 8'd23 : 8'd59);
		end
		bus(1'b1, `ADDR_CONTROL, 8'h00);
		rx(`ADDR_CONTROL, 8'h80, 8'hC0);
		idle(3 * TICK);
		rx(`ADDR_CONTROL, 8'h00, 8'hC0);
		rx(`ADDR_HOURS, 8'd23, 8'hFF);
		// load restarts the sub-second count, so at most one step has gone by
		rx(`ADDR_SUBSECOND, 8'h7E, 8'hFE);
		bus(1'b1, `ADDR_ALARM_MIN, 8'h00);
		bus(1'b1, `ADDR_IRQ_MASK, 8'h01);
		idle(1);
		for (int k = 0; k < 6000 && irq !== 1'b1; k++) @(posedge ref_clk);
		@(negedge ref_clk);
		`CHK(irq, 1'b1)
		@(posedge ref_clk);
		rx(`ADDR_HOURS, 8'h00, 8'hFF);
		rx(`ADDR_MINUTES, 8'h00, 8'hFF);
		rx(`ADDR_WEEKDAY, 8'h02, 8'hFF);
		rx(`ADDR_DATE, 8'h02, 8'hFF);
		rx(`ADDR_IRQ_STATUS, 8'h01, 8'h01);
		bus(1'b1, `ADDR_IRQ_MASK, 8'h00);
		idle(1);
		@(negedge ref_clk);
		`CHK(irq, 1'b0)
		@(posedge ref_clk);
		bus(1'b1, `ADDR_CONTROL, 8'h40);
		rx(`ADDR_CONTROL, 8'h40, 8'hC0);
		idle(4200);
		rx(`ADDR_SECONDS, 8'h00, 8'hFF);
		bus(1'b1, `ADDR_CONTROL, 8'h00);
		idle(2 * TICK);
		rx(`ADDR_SECONDS, 8'h01, 8'hFF);
		bus(1'b1, `ADDR_IRQ_STATUS, 8'h01);
		rx(`ADDR_IRQ_STATUS, 8'h00, 8'h01);
		bus(1'b1, `ADDR_IRQ_MASK, 8'h02);
		idle(1);
		count_error <= 1'b1;
		@(posedge ref_clk);
		count_error <= 1'b0;
		rx(`ADDR_CONTROL, 8'h10, 8'hD0);
		@(negedge ref_clk);
		`CHK(irq, 1'b1)
		@(posedge ref_clk);
		bus(1'b1, `ADDR_CONTROL, 8'h00);
		rx(`ADDR_CONTROL, 8'h00, 8'hD0);
		rx(`ADDR_SUBSECOND, 8'h00, 8'h80);
		idle(3);
		tally_and_finish();
	end
endmodule
